// >>> verilog/scei_codec.v
// sector header crc, data crc, 20-way ecc encoder/checker, resync marking
// assumes synchronous inputs on mclk; downstream accepts one byte per cycle
`timescale 1ns/1ps
`include "scei_map.vh"

// Contract
// - header crc covers first three identifier bytes
// - header polynomial x16+x12+x5+1
// - invert top two bytes, shift by x16
// - remainder bit 15 into byte four msb
// - user, eight ff, four crc, 320 ecc
// - ecc byte order column first, position second
// - twenty column matrix, rows descending
// - gf(256) with x8+x5+x3+x2+1
// - crc roots alpha 136 to 139
// - data crc over user and fill only
// - row sums weighted by row index
// - ecc roots alpha 120 to 135
// - ecc remainders cleared per sector
// - ecc check bytes sent inverted
// - twenty codewords, one per column
// - highest remainder coefficient sent first
// - modulator picks resync pattern and x/y
// - resync after every sixtieth byte, 1..39
// - sequence starts right after sync bytes
// - output follows recording row order
// - byte wrong if any bit wrong
module scei_codec (
    input  wire        mclk,
    input  wire        rstn,
    input  wire        sector_start,
    input  wire        mode,
    input  wire [7:0]  in_byte,
    input  wire        in_valid,
    output reg         in_ready,
    output reg         out_valid,
    output reg  [7:0]  out_byte,
    output reg         resync_field,
    output reg  [5:0]  resync_num,
    output reg         busy,
    output reg         sector_done,
    output reg         data_crc_err,
    output reg         ecc_err,
    input  wire        hdr_start,
    input  wire [23:0] hdr_bytes,
    input  wire [15:0] hdr_crc_in,
    output reg  [15:0] header_identifier_field_crc,
    output reg         hdr_done,
    output reg         hdr_crc_err
);
    function [7:0] gf_mul;
        input [7:0] a;
        input [7:0] b;
        reg   [7:0] p;
        reg   [7:0] x;
        integer     i;
        begin
            p = 8'h00;
            x = a;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i])
                    p = p ^ x;
                x = x[7] ? ({x[6:0], 1'b0} ^ `SCEI_GF_POLY) : {x[6:0], 1'b0};
            end
            gf_mul = p;
        end
    endfunction

    // alpha^i = (beta^i)^88, beta = 2 in polynomial basis
    function [7:0] gf_alpha;
        input integer e;
        reg   [7:0]   p;
        integer       i;
        begin
            p = 8'h01;
            for (i = 0; i < (e * `SCEI_ALPHA_EXP) % 255; i = i + 1)
                p = gf_mul(p, 8'h02);
            gf_alpha = p;
        end
    endfunction

    // monic product of (x + alpha^i); byte k holds coefficient of x^k
    function [135:0] gen_poly;
        input integer first;
        input integer cnt;
        reg   [135:0] p;
        reg   [135:0] q;
        reg   [7:0]   a;
        integer       i;
        integer       k;
        begin
            p = 136'h1;
            for (i = 0; i < cnt; i = i + 1) begin
                a = gf_alpha(first + i);
                q = p << 8;
                for (k = 0; k < 17; k = k + 1)
                    q[8*k +: 8] = q[8*k +: 8] ^ gf_mul(a, p[8*k +: 8]);
                p = q;
            end
            gen_poly = p;
        end
    endfunction

    function [15:0] hdr_crc;
        input [23:0] b;
        reg   [23:0] m;
        reg   [15:0] r;
        reg          fb;
        integer      i;
        begin
            m = {~b[23:8], b[7:0]};
            r = 16'h0000;
            for (i = 23; i >= 0; i = i - 1) begin
                fb = m[i] ^ r[15];
                r = {r[14:0], 1'b0} ^ (fb ? `SCEI_HDR_POLY : 16'h0000);
            end
            hdr_crc = r;
        end
    endfunction

    wire [135:0] crc_gen = gen_poly(`SCEI_CRC_ROOT0, `SCEI_CRC_NROOT);
    wire [135:0] ecc_gen = gen_poly(`SCEI_ECC_ROOT0, `SCEI_ECC_NROOT);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg          state;
    reg          chk;
    reg  [11:0]  cnt;
    reg  [4:0]   col;
    reg  [5:0]   sixty;
    reg  [5:0]   rs_cnt;
    reg  [7:0]   rowsum;
    reg  [31:0]  crc_r;
    reg  [127:0] ecc_mem [0:19];

    wire [11:0]  n        = cnt + 12'd1;
    wire         in_phase = chk || (n <= `SCEI_USER_LAST);
    wire         go       = (state == ST_RUN) && (in_phase ? (in_valid && in_ready) : 1'b1);
    wire [127:0] ecc_cur  = ecc_mem[col];

    reg  [7:0]   cur;
    reg  [7:0]   next_rowsum;
    reg  [31:0]  next_crc;
    reg  [127:0] next_ecc;
    reg  [7:0]   fb;
    reg          crc_bad;
    reg          ecc_bad;
    integer      k;

    always @* begin
        cur = in_byte;
        crc_bad = 1'b0;
        ecc_bad = 1'b0;
        fb = 8'h00;
        k = 0;
        if (!chk) begin
            if (n > `SCEI_CRC_LAST)
                cur = ~ecc_cur[127:120];
            else if (n > `SCEI_FILL_LAST)
                cur = crc_r[31:24];
            else if (n > `SCEI_USER_LAST)
                cur = `SCEI_FILL_BYTE;
        end else begin
            // any differing bit marks the byte bad
            if (n > `SCEI_CRC_LAST)
                ecc_bad = (in_byte != ~ecc_cur[127:120]);
            else if (n > `SCEI_FILL_LAST)
                crc_bad = (in_byte != crc_r[31:24]);
        end
        next_rowsum = rowsum ^ cur;
        next_crc = crc_r;
        if (n > `SCEI_FILL_LAST && n <= `SCEI_CRC_LAST) begin
            next_crc = {crc_r[23:0], 8'h00};
        end else if (n <= `SCEI_FILL_LAST &&
                     ((col == `SCEI_COL_LAST && n <= `SCEI_ROW0_LAST) ||
                      n == `SCEI_FILL_LAST)) begin
            // row 0 closes after its sixteenth byte
            fb = next_rowsum ^ crc_r[31:24];
            next_crc = {crc_r[23:0], 8'h00};
            for (k = 0; k < 4; k = k + 1)
                next_crc[8*k +: 8] = next_crc[8*k +: 8] ^ gf_mul(fb, crc_gen[8*k +: 8]);
        end
        fb = cur ^ ecc_cur[127:120];
        next_ecc = {ecc_cur[119:0], 8'h00};
        if (n <= `SCEI_CRC_LAST) begin
            for (k = 0; k < 16; k = k + 1)
                next_ecc[8*k +: 8] = next_ecc[8*k +: 8]
                    ^ gf_mul(fb, ecc_gen[8*k +: 8]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 20; g = g + 1) begin : g_col
            always @(posedge mclk or negedge rstn) begin
                if (!rstn)
                    ecc_mem[g] <= 128'h0;
                else if (sector_start && state == ST_IDLE)
                    ecc_mem[g] <= 128'h0;
                else if (go && col == g)
                    ecc_mem[g] <= next_ecc;
            end
        end
    endgenerate

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state        <= ST_IDLE;
            chk          <= `SCEI_MODE_ENCODE;
            cnt          <= 12'd0;
            col          <= 5'd0;
            sixty        <= 6'd0;
            rs_cnt       <= 6'd0;
            rowsum       <= 8'h00;
            crc_r        <= 32'h0;
            in_ready     <= 1'b0;
            out_valid    <= 1'b0;
            out_byte     <= 8'h00;
            resync_field <= 1'b0;
            resync_num   <= 6'd0;
            busy         <= 1'b0;
            sector_done  <= 1'b0;
            data_crc_err <= 1'b0;
            ecc_err      <= 1'b0;
        end else begin
            out_valid    <= 1'b0;
            resync_field <= 1'b0;
            sector_done  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (sector_start) begin
                        state        <= ST_RUN;
                        chk          <= mode;
                        cnt          <= 12'd0;
                        col          <= 5'd0;
                        sixty        <= 6'd0;
                        rs_cnt       <= 6'd0;
                        rowsum       <= 8'h00;
                        crc_r        <= 32'h0;
                        in_ready     <= 1'b1;
                        busy         <= 1'b1;
                        data_crc_err <= 1'b0;
                        ecc_err      <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (go) begin
                        out_valid <= 1'b1;
                        out_byte  <= cur;
                        cnt       <= n;
                        col       <= (col == `SCEI_COL_LAST) ? 5'd0 : col + 5'd1;
                        crc_r     <= next_crc;
                        rowsum    <= (col == `SCEI_COL_LAST || n == `SCEI_FILL_LAST)
                                     ? 8'h00 : next_rowsum;
                        if (crc_bad)
                            data_crc_err <= 1'b1;
                        if (ecc_bad)
                            ecc_err <= 1'b1;
                        if (sixty == `SCEI_RS_PERIOD - 6'd1) begin
                            sixty <= 6'd0;
                            if (rs_cnt != `SCEI_RS_LAST) begin
                                rs_cnt       <= rs_cnt + 6'd1;
                                resync_field <= 1'b1;
                                resync_num   <= rs_cnt + 6'd1;
                            end
                        end else begin
                            sixty <= sixty + 6'd1;
                        end
                        if (n == `SCEI_SEQ_LAST) begin
                            state       <= ST_IDLE;
                            busy        <= 1'b0;
                            in_ready    <= 1'b0;
                            sector_done <= 1'b1;
                        end else if (!chk && n == `SCEI_USER_LAST) begin
                            in_ready <= 1'b0;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            header_identifier_field_crc <= 16'h0000;
            hdr_done                    <= 1'b0;
            hdr_crc_err                 <= 1'b0;
        end else begin
            hdr_done <= hdr_start;
            if (hdr_start) begin
                header_identifier_field_crc <= hdr_crc(hdr_bytes);
                hdr_crc_err <= (hdr_crc(hdr_bytes) != hdr_crc_in);
            end
        end
    end
endmodule // scei_codec

// >>> verilog/scei_map.vh
// constants for the sector crc / ecc / interleave block
// assumes one byte clock; the user, fill, crc, seq and row0 limits are sequence byte numbers
`ifndef SCEI_MAP_VH
`define SCEI_MAP_VH
`define SCEI_USER_LAST    12'd2048
`define SCEI_FILL_LAST    12'd2056
`define SCEI_CRC_LAST     12'd2060
`define SCEI_SEQ_LAST     12'd2380
`define SCEI_ROW0_LAST    12'd2040
`define SCEI_COLS         5'd20
`define SCEI_COL_LAST     5'd19
`define SCEI_RS_PERIOD    6'd60
`define SCEI_RS_LAST      6'd39
`define SCEI_FILL_BYTE    8'hff
`define SCEI_GF_POLY      8'h2d
`define SCEI_HDR_POLY     16'h1021
`define SCEI_ALPHA_EXP    88
`define SCEI_CRC_ROOT0    136
`define SCEI_CRC_NROOT    4
`define SCEI_ECC_ROOT0    120
`define SCEI_ECC_NROOT    16
`define SCEI_MODE_ENCODE  1'b0
`define SCEI_MODE_CHECK   1'b1
`endif

// >>> bench/scei_codec_monitor.sv
// assertion checker for scei_codec, sees only its ports
// assumes it is bound to every scei_codec instance by the bind below
`timescale 1ns/1ps
module scei_codec_monitor (
    input wire        mclk,
    input wire        rstn,
    input wire        sector_start,
    input wire        in_valid,
    input wire        in_ready,
    input wire        out_valid,
    input wire        resync_field,
    input wire [5:0]  resync_num,
    input wire        busy,
    input wire        sector_done,
    input wire        hdr_start,
    input wire [15:0] hdr_crc_in,
    input wire [15:0] header_identifier_field_crc,
    input wire        hdr_done,
    input wire        hdr_crc_err
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // fill bytes follow the last user byte without a gap
    sequence s_burst; out_valid [*8]; endsequence
    property p_hdr_done; hdr_start |=> hdr_done; endproperty
    property p_hdr_err;
        hdr_start |=> hdr_crc_err == (header_identifier_field_crc != $past(hdr_crc_in));
    endproperty
    property p_start; sector_start && !busy |=> busy && in_ready; endproperty
    property p_idle; !busy |-> !in_ready; endproperty
    property p_done; sector_done |-> out_valid && !busy; endproperty
    property p_rs_out; resync_field |-> out_valid; endproperty
    property p_rs_num; resync_field |-> resync_num inside {[1:39]} &&
        (resync_num == 6'h01 || resync_num == $past(resync_num) + 6'h01); endproperty
    property p_take; in_valid && in_ready |=> out_valid; endproperty
    property p_fill; $fell(in_ready) && busy |-> s_burst; endproperty
    a_hdr_done: assert property (p_hdr_done) else $error("no hdr_done");
    a_hdr_err: assert property (p_hdr_err) else $error("hdr_crc_err wrong");
    a_start: assert property (p_start) else $error("no start");
    a_idle: assert property (p_idle) else $error("ready while idle");
    a_done: assert property (p_done) else $error("bad done");
    a_rs_out: assert property (p_rs_out) else $error("resync alone");
    a_rs_num: assert property (p_rs_num) else $error("resync number");
    a_take: assert property (p_take) else $error("no output");
    a_fill: assert property (p_fill) else $error("fill gap");
endmodule // scei_codec_monitor
bind scei_codec scei_codec_monitor u_mon (.mclk(mclk), .rstn(rstn),
    .sector_start(sector_start), .in_valid(in_valid), .in_ready(in_ready),
    .out_valid(out_valid), .resync_field(resync_field), .resync_num(resync_num),
    .busy(busy), .sector_done(sector_done), .hdr_start(hdr_start), .hdr_crc_in(hdr_crc_in),
    .header_identifier_field_crc(header_identifier_field_crc), .hdr_done(hdr_done),
    .hdr_crc_err(hdr_crc_err));

// >>> bench/scei_source.sv
// byte source model on the controller side of scei_codec
// assumes the bench fills mem and pulses go with sector_start
`timescale 1ns/1ps
module scei_source (
    input  wire        mclk,
    input  wire        rstn,
    input  wire        go,
    input  wire        slow,
    input  wire [11:0] total,
    input  wire        in_ready,
    output reg         in_valid,
    output reg  [7:0]  in_byte
);
    reg [7:0] mem [1:2380];
    integer   n;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            in_valid <= 1'b0;
            in_byte  <= 8'h00;
            n = 1;
        end else begin
            if (in_valid && in_ready) n = n + 1;
            if (go) n = 1;
            // a byte stays put until taken
            if (!in_valid || in_ready) begin
                if (n <= total && !(slow && $urandom % 2)) begin
                    in_valid <= 1'b1;
                    in_byte  <= mem[n];
                end else begin
                    in_valid <= 1'b0;
                    in_byte  <= ~in_byte;
                end
            end
        end
    end
endmodule // scei_source

// >>> bench/scei_codec_tb_top.sv
// self-checking bench for scei_codec with a byte source model
// assumes scei_codec_monitor is bound to the design
`timescale 1ns/1ps
module scei_codec_tb_top;
    reg mclk = 0, rstn = 0, sector_start = 0, mode = 0, hdr_start = 0, go = 0, slow = 0;
    reg [23:0] hdr_bytes = 0;
    reg [15:0] hdr_crc_in = 0;
    reg [11:0] total = 0;
    wire [7:0] in_byte, out_byte;
    wire [5:0] resync_num;
    wire [15:0] hcrc_out;
    wire in_valid, in_ready, out_valid, resync_field, busy, sector_done;
    wire data_crc_err, ecc_err, hdr_done, hdr_crc_err;
    reg [7:0] cap [1:2380];
    integer mismatches = 0, samples_checked = 0, cyc = 0, idx = 0, i, k;
    scei_codec dut (.mclk(mclk), .rstn(rstn), .sector_start(sector_start), .mode(mode),
        .in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
        .out_byte(out_byte), .resync_field(resync_field), .resync_num(resync_num),
        .busy(busy), .sector_done(sector_done), .data_crc_err(data_crc_err),
        .ecc_err(ecc_err), .hdr_start(hdr_start), .hdr_bytes(hdr_bytes),
        .hdr_crc_in(hdr_crc_in), .header_identifier_field_crc(hcrc_out),
        .hdr_done(hdr_done), .hdr_crc_err(hdr_crc_err));
    scei_source src (.mclk(mclk), .rstn(rstn), .go(go), .slow(slow), .total(total),
        .in_ready(in_ready), .in_valid(in_valid), .in_byte(in_byte));
    initial forever #2 mclk = ~mclk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("FAIL t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // header check bits: top two bytes inverted, msb first, times x16
    function [15:0] hcrc(input [23:0] b);
        integer j;
        reg f;
        begin
            hcrc = 16'h0000;
            for (j = 23; j >= 0; j = j - 1) begin
                f = b[j] ^ (j > 7) ^ hcrc[15];
                hcrc = {hcrc[14:0], 1'b0} ^ (f ? 16'h1021 : 16'h0000);
            end
        end
    endfunction
    function [7:0] gmul(input [7:0] a, input [7:0] b);
        integer j;
        reg [7:0] x;
        begin
            gmul = 8'h00;
            x = a;
            for (j = 0; j < 8; j = j + 1) begin
                if (b[j]) gmul = gmul ^ x;
                x = {x[6:0], 1'b0} ^ (x[7] ? 8'h2d : 8'h00);
            end
        end
    endfunction
    // alpha^e is beta^(88 e mod 255), beta = x in polynomial basis
    function [7:0] galpha(input integer e);
        integer j;
        begin
            galpha = 8'h01;
            for (j = 0; j < (88 * e) % 255; j = j + 1) galpha = gmul(galpha, 8'h02);
        end
    endfunction
    // column c codeword at a: rows 102..0, then its 16 check bytes un-inverted
    function [7:0] ecc_syn(input integer c, input [7:0] a);
        integer m;
        begin
            ecc_syn = 8'h00;
            for (m = 0; m < 119; m = m + 1)
                ecc_syn = gmul(ecc_syn, a) ^ cap[c + 1 + 20 * m] ^ ((m > 102) ? 8'hff : 8'h00);
        end
    endfunction
    // row sums 102..1, the sum of the sixteen bytes of row 0, then c1..c4, evaluated at a
    function [7:0] crc_syn(input [7:0] a);
        integer m;
        reg [7:0] s;
        begin
            crc_syn = 8'h00;
            s = 8'h00;
            for (m = 1; m <= 2060; m = m + 1) begin
                if (m <= 2056) s = s ^ cap[m];
                if (((m % 20 == 0) && (m <= 2040)) || (m >= 2056)) begin
                    crc_syn = gmul(crc_syn, a) ^ ((m > 2056) ? cap[m] : s);
                    s = 8'h00;
                end
            end
        end
    endfunction
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (out_valid === 1'b1) begin
            idx = idx + 1;
            cap[idx] = out_byte;
        end
        if (resync_field === 1'b1) begin
            chk(idx % 60, 0);
            chk(resync_num, idx / 60);
        end
        if (sector_done === 1'b1) chk(idx, 2380);
        if (cyc == 60000) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    task run(input m, input [11:0] tot);
        idx = 0;
        @(posedge mclk);
        sector_start <= 1'b1;
        mode <= m;
        total <= tot;
        go <= 1'b1;
        @(posedge mclk);
        sector_start <= 1'b0;
        go <= 1'b0;
        do @(negedge mclk); while (sector_done !== 1'b1);
        @(negedge mclk);
    endtask
    initial begin
        k = $urandom(33);
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge mclk);
            hdr_bytes <= (i == 0) ? 24'h000000 : (i == 1) ? 24'hffffff : $urandom;
            k = i % 2;
            hdr_start <= 1'b1;
            @(posedge mclk);
            hdr_start <= 1'b0;
            hdr_crc_in <= 16'h0000;
            @(negedge mclk);
            chk(hcrc_out, hcrc(hdr_bytes));
        end
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge mclk);
            hdr_crc_in <= hcrc(hdr_bytes) ^ i;
            hdr_start <= 1'b1;
            @(posedge mclk);
            hdr_start <= 1'b0;
            @(negedge mclk);
            chk(hdr_crc_err, i != 0);
        end
        for (i = 1; i <= 2048; i = i + 1) src.mem[i] = (i == 1) ? 8'h00 : $urandom;
        slow = 1'b1;
        run(1'b0, 12'd2048);
        for (i = 1; i <= 2056; i = i + 1)
            chk(cap[i], (i > 2048) ? 8'hff : src.mem[i]);
        for (i = 136; i <= 139; i = i + 1)
            chk(crc_syn(galpha(i)), 0);
        for (i = 120; i <= 135; i = i + 1)
            for (k = 0; k < 20; k = k + 1)
                chk(ecc_syn(k, galpha(i)), 0);
        for (i = 1; i <= 2380; i = i + 1) src.mem[i] = cap[i];
        slow = 1'b0;
        run(1'b1, 12'd2380);
        chk({data_crc_err, ecc_err}, 2'b00);
        for (i = 1; i <= 2380; i = i + 1)
            chk(cap[i], src.mem[i]);
        // corrupt a user byte, a check byte, an ecc byte in turn
        for (i = 0; i < 3; i = i + 1) begin
            k = (i == 0) ? 700 : (i == 1) ? 2058 : 2300;
            src.mem[k] = src.mem[k] ^ 8'h10;
            run(1'b1, 12'd2380);
            chk({data_crc_err, ecc_err}, (i == 2) ? 2'b01 : 2'b11);
            src.mem[k] = src.mem[k] ^ 8'h10;
        end
        wrap_up;
    end
endmodule // scei_codec_tb_top
